// File: rtl/i2c_slave_register_port.sv
`timescale 1ns/10ps
// Functional notes
// - only 7-bit addressing; slave only, no 10-bit or CBUS
// - own address fixed at 0110111, then a direction bit
// - eighth bit low means write, high means read
// - four 8-bit registers reachable over the port
// - works at 100 kbit/s and 400 kbit/s
// - write: addr, ack, index, ack, data, ack, stop
// - combined read returns register chosen by preceding index
// - index pointer set by index-only write, kept across stop
// - later read returns register at stored pointer
// - no auto increment; one register per transfer
// - start and stop frame transfers; repeated start accepted
// - register 0x01 holds four active-high sink enables, default low
module i2c_slave_register_port
  import i2c_port_pkg::*;
(
  input wire logic CLK_I, // 40 MHz system clock
  input wire logic RST_B_I, // sync reset, active low
  input wire logic SCL_I, // serial clock from master
  input wire logic SDA_I, // serial data line level
  output logic SDA_O, // serial data drive value (always low)
  output logic SDA_OE_B_O, // low while pulling data line low
  output logic [BL_EN_W-1:0] BL_EN_O, // backlight sink enables
  output logic [DATA_W-1:0] REG0_O, // register 0 contents
  output logic [DATA_W-1:0] REG2_O, // register 2 contents
  output logic [DATA_W-1:0] REG3_O // register 3 contents
);
  // one-hot codes keep each state decode down to a single flop
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_INDEX = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_RACK = 6'b100000
  } state_e;

  logic scl, scl_rise, scl_fall;
  logic sda, sda_rise, sda_fall;
  state_e state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [DATA_W-1:0] shift_reg, shift_next;
  logic [IDX_W-1:0] ptr_reg, ptr_next;
  logic lead_reg, lead_next;
  logic rd_reg, rd_next;
  logic drive_reg, drive_next;
  logic oe_b_reg, oe_b_next;
  logic [DATA_W-1:0] regs_reg [REG_COUNT];
  logic [DATA_W-1:0] regs_next [REG_COUNT];
  logic [DATA_W-1:0] tx_byte;
  logic start_cond, stop_cond;

  // sampled bus lines
  // both lines share one sync depth, so start and stop keep their order
  i2c_line_sync u_scl_sync (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .line_i(SCL_I),
    .line_o(scl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );

  i2c_line_sync u_sda_sync (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .line_i(SDA_I),
    .line_o(sda),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  // framing conditions: data moves while clock is high
  // start stop framing
  assign start_cond = scl & sda_fall;
  assign stop_cond = scl & sda_rise;

  // the register at the pointer; no increment anywhere
  // single register access
  assign tx_byte = regs_reg[ptr_reg];

  // protocol state machine; an unknown state returns to idle
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    lead_next = lead_reg;
    rd_next = rd_reg;
    drive_next = drive_reg;
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (start_cond) begin
      state_next = ST_ADDR;
      bit_next = BIT_ZERO;
      lead_next = 1'b1;
      drive_next = 1'b0;
    end else if (stop_cond) begin
      // pointer kept across stop
      // a stop also ends a byte that the master cut short
      state_next = ST_IDLE;
      drive_next = 1'b0;
    end else if (scl_rise && state_reg != ST_IDLE) begin
      // sample a data bit or the master's ack
      if (bit_reg < BIT_ACK) begin
        shift_next = {shift_reg[DATA_W-2:0], sda};
      end else if (state_reg == ST_RACK) begin
        // master nack ends the read
        // an ack from the master ends it too: one byte per read
        state_next = ST_IDLE;
      end
    end else if (scl_fall && state_reg != ST_IDLE) begin
      drive_next = 1'b0;
      if (lead_reg) begin
        // the fall that closes a start carries no bit, so it is not counted
        lead_next = 1'b0;
      end else if (bit_reg == BIT_LAST) begin
        bit_next = BIT_ACK;
        case (state_reg)
          ST_ADDR: begin
            if (shift_reg[DATA_W-1:1] == SLAVE_ADDR) begin
              drive_next = 1'b1;
              rd_next = shift_reg[0];
            end else begin
              // stay silent until the next start; another slave owns the bus
              state_next = ST_IDLE;
            end
          end
          ST_INDEX: begin
            drive_next = 1'b1;
            // load index pointer
            // indexes above three alias onto the low two bits
            ptr_next = shift_reg[IDX_W-1:0];
          end
          ST_WDATA: begin
            drive_next = 1'b1;
            regs_next[ptr_reg] = shift_reg;
          end
          ST_RDATA: begin
            state_next = ST_RACK;
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end else if (bit_reg == BIT_ACK) begin
        bit_next = BIT_ZERO;
        case (state_reg)
          ST_ADDR: begin
            if (rd_reg) begin
              state_next = ST_RDATA;
              drive_next = ~tx_byte[DATA_W-1];
            end else begin
              state_next = ST_INDEX;
            end
          end
          ST_INDEX: state_next = ST_WDATA;
          // one data byte only; further bytes are ignored
          ST_WDATA: state_next = ST_IDLE;
          default: state_next = ST_IDLE;
        endcase
      end else begin
        bit_next = bit_reg + 4'h1;
        if (state_reg == ST_RDATA) begin
          drive_next = ~tx_byte[3'(BIT_LAST - bit_reg) - 3'h1];
        end
      end
    end
    // the pin enable has its own flop so the output comes straight off a register
    oe_b_next = ~drive_next;
  end

  // state registers; registers reset to zero so sinks start disabled
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_reg <= ST_IDLE;
      bit_reg <= BIT_ZERO;
      shift_reg <= '0;
      ptr_reg <= '0;
      lead_reg <= 1'b0;
      rd_reg <= 1'b0;
      drive_reg <= 1'b0;
      oe_b_reg <= 1'b1;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= REG_RESET_VALUE;
      end
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      lead_reg <= lead_next;
      rd_reg <= rd_next;
      drive_reg <= drive_next;
      oe_b_reg <= oe_b_next;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // open drain: only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE_B_O = oe_b_reg;
  assign BL_EN_O = regs_reg[BL_ENABLE_IDX[IDX_W-1:0]][BL_EN_W-1:0];
  assign REG0_O = regs_reg[0];
  assign REG2_O = regs_reg[2];
  assign REG3_O = regs_reg[3];
endmodule

// File: common/i2c_port_pkg.sv
package i2c_port_pkg;
  // fixed 7-bit slave address, pattern 0110111
  localparam logic [6:0] SLAVE_ADDR = 7'h37;
  localparam int REG_COUNT = 4;
  localparam int DATA_W = 8;
  localparam int IDX_W = 2;
  // register that holds the sink enables
  localparam logic [7:0] BL_ENABLE_IDX = 8'h01;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam int BL_EN_W = 4;
endpackage

// File: rtl/i2c_line_sync.sv
`timescale 1ns/10ps
module i2c_line_sync
  import i2c_port_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic line_i, // asynchronous line
  output logic line_o, // synchronised level
  output logic rise_o, // rising edge pulse
  output logic fall_o // falling edge pulse
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;

  // two flops then one more for edge detect; meta_reg feeds only sync_reg
  always_comb begin
    meta_next = line_i;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // idle bus is high, so reset to one avoids a false edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign line_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;
endmodule

// File: tb/port_chk.sv
`timescale 1ns/10ps
module port_chk
  import i2c_port_pkg::*;
(
  input wire logic CLK_I, // clock
  input wire logic RST_B_I, // reset
  input wire logic SCL_I, // bus clock
  input wire logic SDA_I, // bus data
  input wire logic SDA_O, // drive value
  input wire logic SDA_OE_B_O, // drive enable
  input wire logic [BL_EN_W-1:0] BL_EN_O, // enables
  input wire logic [DATA_W-1:0] REG0_O, // reg 0
  input wire logic [DATA_W-1:0] REG2_O, // reg 2
  input wire logic [DATA_W-1:0] REG3_O // reg 3
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [15:0] drive_reg;
  // length of the present pull, in clocks
  always_ff @(posedge CLK_I) begin
    drive_reg <= SDA_OE_B_O ? 16'h0000 : drive_reg + 16'h0001;
  end
  // a stop on the wire, then a quiet line
  sequence stop_seen;
    SCL_I && $rose(SDA_I);
  endsequence
  sequence quiet4;
    SDA_OE_B_O [*4];
  endsequence
  a_drive_value_low: assert property (SDA_O == 1'b0)
    else $error("drive value not low");
  a_reset_clear: assert property ($rose(RST_B_I) |-> SDA_OE_B_O && BL_EN_O == 4'h0
    && {REG0_O, REG2_O, REG3_O} == 24'h000000) else $error("outputs not cleared");
  a_pull_scl_low: assert property ($fell(SDA_OE_B_O) |-> $past(!SCL_I, 3))
    else $error("pull began with clock high");
  a_release_scl_low: assert property ($rose(SDA_OE_B_O) |-> $past(!SCL_I, 3))
    else $error("release with clock high");
  a_pull_holds: assert property ($fell(SDA_OE_B_O) |=> !SDA_OE_B_O [*3])
    else $error("pull too short");
  a_quiet_stop: assert property (stop_seen |=> quiet4)
    else $error("drive after stop");
  a_write_acked: assert property ($changed({BL_EN_O, REG0_O, REG2_O, REG3_O})
    && $past(RST_B_I) |-> ##[0:8] !SDA_OE_B_O) else $error("write without ack");
  a_pull_bounded: assert property (drive_reg < 16'h0320)
    else $error("pull too long");
endmodule

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i, // bench clock
  input wire logic sda_i, // resolved data
  output logic scl_o, // bus clock, idle high
  output logic sda_o // 1 releases data
);
  logic in_frame; // set between a start and its stop
  // bus clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    in_frame = 1'b0;
  end
  // one bit; data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    scl_o <= 1'b0;
    @(posedge clk_i) sda_o <= b;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    r = sda_i;
  endtask
  // start or repeated start; an idle bus gets no stray clock pulse first
  task automatic start();
    logic r;
    if (in_frame) begin
      bit_x(1'b1, r);
    end
    sda_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    in_frame = 1'b1;
  endtask
  task automatic stop();
    logic r;
    bit_x(1'b0, r);
    sda_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    in_frame = 1'b0;
  endtask
  // msb first; the ninth bit pulled low is the ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic read_reg(output logic [7:0] d, output logic ack);
    logic r;
    start();
    send(8'h6f, ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(1'b1, r);
    stop();
  endtask
  // pointer only; caller ends with stop or restart
  task automatic set_ptr(input logic [7:0] a, input logic [7:0] i, output logic ack);
    logic k;
    start();
    send(a, ack);
    send(i, k);
  endtask
  task automatic write_reg(input logic [7:0] i, input logic [7:0] d, output logic [2:0] k);
    start();
    send(8'h6e, k[2]);
    send(i, k[1]);
    send(d, k[0]);
    stop();
  endtask
endmodule

// File: tb/tb_i2c_slave_register_port.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb_i2c_slave_register_port;
  import i2c_port_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sda_m, sda_d, oe_b, a, a1;
  logic [3:0] bl;
  logic [7:0] r0, r2, r3, d;
  logic [2:0] k;
  wire sda;
  int fails = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  // pull-up: low only while a party pulls
  assign sda = sda_m & (oe_b | sda_d);
  host_model host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  i2c_slave_register_port i2c_slave_register_port_i (.CLK_I(clk), .RST_B_I(rst_b),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_d), .SDA_OE_B_O(oe_b), .BL_EN_O(bl),
    .REG0_O(r0), .REG2_O(r2), .REG3_O(r3));
  task automatic complete_run();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // each index lands in its own register
  task automatic s_write();
    for (int i = 0; i < 4; i++) begin
      host_model_i.write_reg(8'(i), 8'(8'h51 + i * 17), k);
      `CHK(k, 3'b111, "write acks")
    end
    `CHK({r0, r2, r3}, 24'h517384, "register contents")
    `CHK(bl, 4'h2, "sink enables")
  endtask
  // index then repeated start, no stop between
  task automatic s_combined();
    host_model_i.set_ptr(8'h6e, 8'h02, a);
    host_model_i.read_reg(d, a1);
    `CHK({a, a1}, 2'b11, "acks")
    `CHK(d, 8'h73, "combined read")
  endtask
  // pointer survives a stop and a visit to another slave, and never steps
  task automatic s_stop_sep();
    host_model_i.set_ptr(8'h6e, 8'h03, a);
    host_model_i.stop();
    host_model_i.set_ptr(8'h20, 8'h00, a1);
    host_model_i.stop();
    `CHK({a, a1}, 2'b10, "acks")
    for (int i = 0; i < 2; i++) begin
      host_model_i.read_reg(d, a);
      `CHK(d, 8'h84, "stored pointer read")
      `CHK(a, 1'b1, "read ack")
    end
  endtask
  // address one bit away is ignored whole
  task automatic s_foreign();
    host_model_i.set_ptr(8'h6c, 8'h00, a);
    host_model_i.send(8'hff, a1);
    host_model_i.stop();
    `CHK({a, a1}, 2'b00, "no acks")
    `CHK(r0, 8'h51, "register kept")
  endtask
  // a byte past the single data byte is refused and lands nowhere
  task automatic s_extra();
    host_model_i.set_ptr(8'h6e, 8'h01, k[2]);
    host_model_i.send(8'h62, k[1]);
    host_model_i.send(8'hae, k[0]);
    host_model_i.stop();
    `CHK(k, 3'b110, "extra byte acks")
    `CHK({bl, r2}, 12'h273, "no step to next")
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({bl, r0, r2, r3, oe_b}, 29'h1, "reset values")
    s_write();
    s_combined();
    s_stop_sep();
    s_foreign();
    s_extra();
    complete_run();
  end
  // cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
bind i2c_slave_register_port port_chk port_chk_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_B_O(SDA_OE_B_O), .BL_EN_O(BL_EN_O),
  .REG0_O(REG0_O), .REG2_O(REG2_O), .REG3_O(REG3_O));
